// *** sftc_pkg.sv ***
// constants for the spi fifo and transfer control block
// assumes a 32-bit apb slave with byte addresses
package sftc_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_CTRL   = 8'h00;
	localparam logic [7:0] OFF_FSIZE  = 8'h04;
	localparam logic [7:0] OFF_STAT   = 8'h08;
	localparam logic [7:0] OFF_ICLR   = 8'h0c;
	localparam logic [7:0] OFF_RXD    = 8'h10;
	localparam logic [7:0] OFF_TXD    = 8'h14;
	localparam logic [7:0] OFF_CLKGEN = 8'h18;
	localparam logic [7:0] OFF_MIS    = 8'h20;
	localparam logic [7:0] OFF_RIS    = 8'h24;
	// control fields
	localparam int C_EN    = 0;
	localparam int C_MST   = 1;
	localparam int C_DMA   = 2;
	localparam int C_IE_TD = 3;
	localparam int C_IE_RA = 4;
	localparam int C_IE_UR = 5;
	localparam int C_IE_OV = 6;
	localparam int C_SRST  = 7;
	localparam int C_CNT_LO = 16;
	localparam logic [31:0] CTRL_RST   = 32'h0001_0000;
	localparam logic [5:0]  FSIZE_RST  = 6'h04;
	localparam logic [7:0]  CLKGEN_RST = 8'h07;
	// status bits
	localparam int S_SENT  = 0;
	localparam int S_RXFUL = 1;
	localparam int S_RXEMP = 2;
	localparam int S_TXFUL = 3;
	localparam int S_TXEMP = 4;
	localparam int S_TXNXT = 5;
	localparam int S_UR    = 6;
	localparam int S_OV    = 7;
	localparam int S_BUSY  = 8;
	// raw interrupt bits
	localparam int R_TD = 0;
	localparam int R_RA = 1;
	localparam int R_UR = 2;
	localparam int R_OV = 3;
	// fifo shape
	localparam int FIFO_DEPTH = 4;
	localparam int FIFO_WIDTH = 32;
	localparam logic [2:0]  FIFO_FULL_CNT = 3'd4;
	localparam logic [16:0] CNT_WRAP = 17'h1_0000;
	localparam logic [5:0]  FSIZE_MAX = 6'd32;
	typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_HALT} sftc_state_t;
endpackage

// *** sftc_slave_model.sv ***
// spi slave device model for the far side of the link
// assumes mode 0 framing, msb first; released line shows inverse level
`timescale 1ns/1ps
module sftc_slave_model (
	// link
	input  wire logic        sclk,
	input  wire logic        ss_n,
	input  wire logic        mosi,
	output logic             miso,
	// frame setup
	input  wire logic [31:0] tx_word,
	input  wire logic [5:0]  bits,
	output logic [31:0]      rx_word
);
	logic [31:0] sh;
	int          cnt;
	initial begin
		miso = 1'b0;
		rx_word = 32'h0;
	end
	always @(negedge ss_n) begin
		sh = tx_word << (32 - bits);
		cnt = 0;
		miso = sh[31];
	end
	always @(posedge sclk) if (!ss_n) rx_word = {rx_word[30:0], mosi};
	always @(negedge sclk) if (!ss_n) begin
		cnt = cnt + 1;
		sh = (cnt == bits) ? tx_word << (32 - bits) : sh << 1;
		if (cnt == bits) cnt = 0;
		miso = sh[31];
	end
	always @(posedge ss_n) miso = ~miso;
endmodule

// *** sftc_top.sv ***
// spi fifo, frame counting, error and interrupt logic with apb registers
// assumes spi pins from outside the pclk domain; mode 0 framing
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ps
// Function
// - separate transmit and receive fifos, 4x32
// - status shows transmit fifo full and empty
// - status shows receive fifo full and empty
// - burst count to 64k, done after all
// - frame count resets to one
// - frame size sets bits per frame
// - count frames, drop output enable at end
// - last frame sets sent flag and interrupt
// - empty fifo on demand: underrun, halt
// - slave request on empty fifo: underrun
// - full receive fifo: overflow, drop, continue
// - underrun and overflow can raise interrupt
// - status shows transmit empty after next read
// - receive available output while data waits
// - ready for more when done, not full
// - dma mode masks done and available interrupts
// - all sources onto one interrupt line
// - reset clears both fifos and pointers
module sftc_top
	import sftc_pkg::*;
(
	// apb
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// spi pins
	input  wire logic        sclk_i,
	input  wire logic        ss_i_n,
	input  wire logic        din_i,
	output logic             sclk_o,
	output logic             sclk_oe_n,
	output logic             ss_o_n,
	output logic             dout_o,
	output logic             dout_oe_n,
	// interrupt and dma
	output logic             irq,
	output logic             rx_data_available,
	output logic             tx_ready_for_more
);
	function automatic logic sel(input logic [7:0] a, input logic [7:0] off);
		sel = (a == off);
	endfunction

	logic [31:0]    ctrl_r;
	logic [5:0]     fsize_r;
	logic [7:0]     clkgen_r;
	logic [3:0]     ris_r;
	logic           sent_r;
	logic [31:0]    txm_r [0:FIFO_DEPTH-1];
	logic [31:0]    rxm_r [0:FIFO_DEPTH-1];
	logic [2:0]     txw_r;
	logic [2:0]     txr_r;
	logic [2:0]     rxw_r;
	logic [2:0]     rxr_r;
	logic [2:0]     sclk_q_r;
	logic [2:0]     ss_q_r;
	logic [1:0]     din_q_r;
	sftc_state_t    st_r;
	sftc_state_t    st_nxt;
	logic [7:0]     div_r;
	logic           sclk_r;
	logic [4:0]     bit_r;
	logic [16:0]    frames_r;
	logic [31:0]    sh_r;
	logic [31:0]    rsh_r;
	logic [31:0]    prdata_r;
	logic [31:0]    rdata_nxt;
	logic           pready_r;
	logic           pslverr_r;
	logic           sclk_oe_n_r;
	logic           ss_o_n_r;
	logic           dout_r;
	logic           dout_oe_n_r;
	logic           irq_r;
	logic           rxav_r;
	logic           txrfm_r;

	// fifo occupancy
	wire [2:0] tx_cnt   = txw_r - txr_r;
	wire [2:0] rx_cnt   = rxw_r - rxr_r;
	wire       tx_full  = (tx_cnt == FIFO_FULL_CNT);
	wire       tx_empty = (tx_cnt == 3'd0);
	wire       tx_enext = (tx_cnt == 3'd1);
	wire       rx_full  = (rx_cnt == FIFO_FULL_CNT);
	wire       rx_empty = (rx_cnt == 3'd0);
	wire [31:0] tx_head = txm_r[txr_r[1:0]];
	wire [31:0] rx_head = rxm_r[rxr_r[1:0]];

	// apb decode
	wire setup  = psel & ~penable;
	wire access = psel & penable & pready_r;
	wire wr     = access & pwrite;
	wire rd     = access & ~pwrite;
	wire mapped = sel(paddr, OFF_CTRL) | sel(paddr, OFF_FSIZE) | sel(paddr, OFF_STAT)
		| sel(paddr, OFF_ICLR) | sel(paddr, OFF_RXD) | sel(paddr, OFF_TXD)
		| sel(paddr, OFF_CLKGEN) | sel(paddr, OFF_MIS) | sel(paddr, OFF_RIS);
	wire tx_push = wr & sel(paddr, OFF_TXD) & ~tx_full;
	wire rx_pop  = rd & sel(paddr, OFF_RXD) & ~rx_empty;
	wire [3:0] clr = (wr & sel(paddr, OFF_ICLR)) ? pwdata[3:0] : 4'h0;

	// control fields
	wire        srst   = ctrl_r[C_SRST];
	wire        enable = ctrl_r[C_EN] & ~srst;
	wire        master = ctrl_r[C_MST];
	wire        dma    = ctrl_r[C_DMA];
	wire [15:0] cnt    = ctrl_r[C_CNT_LO +: 16];
	wire [16:0] tgt    = (cnt == 16'h0000) ? CNT_WRAP : {1'b0, cnt};
	wire [5:0]  fs_eff = ((fsize_r == 6'd0) || (fsize_r > FSIZE_MAX)) ? FSIZE_MAX : fsize_r;
	wire [5:0]  fs_m1w = fs_eff - 6'd1;
	wire [4:0]  fs_m1  = fs_m1w[4:0];
	wire [31:0] fmask  = 32'hffff_ffff >> (FSIZE_MAX - fs_eff);

	// link events
	wire ss_act = ~ss_q_r[1];
	wire s_rise = sclk_q_r[1] & ~sclk_q_r[2];
	wire s_fall = ~sclk_q_r[1] & sclk_q_r[2];
	wire tick   = (div_r == clkgen_r);
	wire m_rise = tick & ~sclk_r & (st_r == ST_SHIFT);
	wire m_fall = tick & sclk_r;
	wire smp_ev = master ? m_rise : (s_rise & ss_act);
	wire shf_ev = master ? m_fall : (s_fall & ss_act);

	// frame sequencing
	wire last_bit   = (bit_r == fs_m1);
	wire frame_end  = (st_r == ST_SHIFT) & shf_ev & last_bit;
	wire [16:0] fr1 = frames_r + 17'd1;
	wire last_frame = (fr1 == tgt);
	wire start      = (st_r == ST_IDLE) & enable & (master ? ~tx_empty : ss_act);
	wire more       = frame_end & ~last_frame;
	wire tx_pop     = (start | more) & ~tx_empty;
	wire ur_ev      = (start | more) & tx_empty;
	wire done_ev    = frame_end & last_frame;
	wire rx_push    = frame_end & ~rx_full;
	wire ov_ev      = frame_end & rx_full;
	wire [31:0] rx_word = rsh_r & fmask;

	// interrupts
	wire [3:0] set_ev = {ov_ev, ur_ev, rx_push, done_ev};
	wire [3:0] ris_nxt = (ris_r & ~clr) | set_ev;
	wire [3:0] ien = {ctrl_r[C_IE_OV], ctrl_r[C_IE_UR],
		ctrl_r[C_IE_RA] & ~dma, ctrl_r[C_IE_TD] & ~dma};
	wire [3:0] mis = ris_r & ien;
	wire busy = (st_r != ST_IDLE);
	wire [31:0] status = {23'h0, busy, ris_r[R_OV], ris_r[R_UR], tx_enext,
		tx_empty, tx_full, rx_empty, rx_full, sent_r};

	always_comb begin
		if (sel(paddr, OFF_CTRL)) begin
			rdata_nxt = ctrl_r;
		end else if (sel(paddr, OFF_FSIZE)) begin
			rdata_nxt = {26'h0, fsize_r};
		end else if (sel(paddr, OFF_STAT)) begin
			rdata_nxt = status;
		end else if (sel(paddr, OFF_RXD)) begin
			rdata_nxt = rx_head;
		end else if (sel(paddr, OFF_CLKGEN)) begin
			rdata_nxt = {24'h0, clkgen_r};
		end else if (sel(paddr, OFF_MIS)) begin
			rdata_nxt = {28'h0, mis};
		end else if (sel(paddr, OFF_RIS)) begin
			rdata_nxt = {28'h0, ris_r};
		end else begin
			rdata_nxt = 32'h0;
		end
	end

	always_comb begin
		st_nxt = st_r;
		case (st_r)
			ST_IDLE: begin
				if (start) begin
					st_nxt = tx_empty ? ST_HALT : ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (ur_ev) begin
					st_nxt = ST_HALT;
				end else if (done_ev | ~enable | (~master & ~ss_act)) begin
					st_nxt = ST_IDLE;
				end
			end
			ST_HALT: begin
				if (master | ~ss_act | ~enable) begin
					st_nxt = ST_IDLE;
				end
			end
			default: st_nxt = ST_IDLE;
		endcase
	end

	// apb slave, zero wait states
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0;
		end else begin
			pready_r  <= setup;
			pslverr_r <= setup & ~mapped;
			prdata_r  <= setup ? rdata_nxt : 32'h0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r   <= CTRL_RST;
			fsize_r  <= FSIZE_RST;
			clkgen_r <= CLKGEN_RST;
		end else if (wr) begin
			if (sel(paddr, OFF_CTRL)) ctrl_r <= pwdata;
			if (sel(paddr, OFF_FSIZE)) fsize_r <= pwdata[5:0];
			if (sel(paddr, OFF_CLKGEN)) clkgen_r <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ris_r  <= 4'h0;
			sent_r <= 1'b0;
		end else begin
			ris_r  <= ris_nxt;
			sent_r <= (sent_r & ~clr[R_TD]) | done_ev;
		end
	end

	// fifo storage
	always_ff @(posedge pclk) begin
		if (tx_push) txm_r[txw_r[1:0]] <= pwdata;
		if (rx_push) rxm_r[rxw_r[1:0]] <= rx_word;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txw_r <= 3'd0;
			txr_r <= 3'd0;
			rxw_r <= 3'd0;
			rxr_r <= 3'd0;
		end else if (srst) begin
			txw_r <= 3'd0;
			txr_r <= 3'd0;
			rxw_r <= 3'd0;
			rxr_r <= 3'd0;
		end else begin
			txw_r <= txw_r + {2'b0, tx_push};
			txr_r <= txr_r + {2'b0, tx_pop};
			rxw_r <= rxw_r + {2'b0, rx_push};
			rxr_r <= rxr_r + {2'b0, rx_pop};
		end
	end

	// pin synchronisers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sclk_q_r <= 3'b000;
			ss_q_r   <= 3'b111;
			din_q_r  <= 2'b00;
		end else begin
			sclk_q_r <= {sclk_q_r[1:0], sclk_i};
			ss_q_r   <= {ss_q_r[1:0], ss_i_n};
			din_q_r  <= {din_q_r[0], din_i};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_r <= ST_IDLE;
		end else if (srst) begin
			st_r <= ST_IDLE;
		end else begin
			st_r <= st_nxt;
		end
	end

	// master clock generation
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_r  <= 8'h0;
			sclk_r <= 1'b0;
		end else if ((st_r != ST_SHIFT) | ~master) begin
			div_r  <= 8'h0;
			sclk_r <= 1'b0;
		end else begin
			div_r  <= tick ? 8'h0 : div_r + 8'h1;
			sclk_r <= sclk_r ^ tick;
		end
	end

	// shifters and counters
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sh_r     <= 32'h0;
			rsh_r    <= 32'h0;
			bit_r    <= 5'd0;
			frames_r <= 17'd0;
		end else begin
			if (tx_pop) begin
				sh_r <= tx_head;
			end else if ((st_r == ST_SHIFT) & shf_ev & ~last_bit) begin
				sh_r <= {sh_r[30:0], 1'b0};
			end
			if ((st_r == ST_SHIFT) & smp_ev) rsh_r <= {rsh_r[30:0], din_q_r[1]};
			if (start | (st_r != ST_SHIFT)) begin
				bit_r <= 5'd0;
			end else if (shf_ev) begin
				bit_r <= last_bit ? 5'd0 : bit_r + 5'd1;
			end
			if (start) begin
				frames_r <= 17'd0;
			end else if (frame_end) begin
				frames_r <= fr1;
			end
		end
	end

	// registered outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sclk_oe_n_r <= 1'b1;
			ss_o_n_r    <= 1'b1;
			dout_r      <= 1'b0;
			dout_oe_n_r <= 1'b1;
			irq_r       <= 1'b0;
			rxav_r      <= 1'b0;
			txrfm_r     <= 1'b0;
		end else begin
			sclk_oe_n_r <= ~(enable & master);
			ss_o_n_r    <= ~(master & (st_r == ST_SHIFT));
			dout_r      <= sh_r[fs_m1];
			dout_oe_n_r <= ~((st_r == ST_SHIFT) & (master | ss_act));
			irq_r       <= |mis;
			rxav_r      <= ~rx_empty;
			txrfm_r     <= ~busy & ~tx_full;
		end
	end

	assign prdata            = prdata_r;
	assign pready            = pready_r;
	assign pslverr           = pslverr_r;
	assign sclk_o            = sclk_r;
	assign sclk_oe_n         = sclk_oe_n_r;
	assign ss_o_n            = ss_o_n_r;
	assign dout_o            = dout_r;
	assign dout_oe_n         = dout_oe_n_r;
	assign irq               = irq_r;
	assign rx_data_available = rxav_r;
	assign tx_ready_for_more = txrfm_r;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_fifo_bound: assert property (tx_cnt <= 3'd4 && rx_cnt <= 3'd4)
		else $error("fifo count above depth");
	a_tx_flags: assert property (setup && sel(paddr, OFF_STAT) |=> prdata[S_TXFUL] ==
		$past(tx_full) && prdata[S_TXEMP] == $past(tx_empty))
		else $error("tx flags wrong");
	a_rx_flags: assert property (setup && sel(paddr, OFF_STAT) |=> prdata[S_RXFUL] ==
		$past(rx_full) && prdata[S_RXEMP] == $past(rx_empty))
		else $error("rx flags wrong");
	a_empty_next: assert property (setup && sel(paddr, OFF_STAT) |=>
		prdata[S_TXNXT] == ($past(tx_cnt) == 3'd1))
		else $error("empty next flag wrong");
	a_done_sets: assert property (done_ev |=> ris_r[R_TD] && sent_r)
		else $error("done not flagged");
	a_count_reset: assert property ($rose(presetn) |-> cnt == 16'h0001)
		else $error("frame count not one");
	a_frame_bits: assert property (frame_end |-> bit_r == fs_m1 ##1 bit_r == 5'd0)
		else $error("frame bit count");
	a_oe_drop: assert property (done_ev |-> ##2 dout_oe_n)
		else $error("oe not dropped after last frame");
	a_underrun: assert property (ur_ev |=> st_r == ST_HALT && ris_r[R_UR])
		else $error("underrun not handled");
	a_overflow: assert property (ov_ev && !srst |=> ris_r[R_OV] && $stable(rxw_r))
		else $error("overflow not handled");
	a_irq_line: assert property (|mis |=> irq)
		else $error("irq not raised");
	a_dma_mask: assert property (dma |-> !mis[R_TD] && !mis[R_RA])
		else $error("dma mode not masking");
	a_rx_avail: assert property (!rx_empty |=> rx_data_available)
		else $error("rx available missing");
	a_tx_rfm: assert property (tx_ready_for_more |-> $past(!busy && !tx_full))
		else $error("ready for more wrong");
	a_srst_clear: assert property (srst |=> tx_empty && rx_empty)
		else $error("fifos not cleared");
	a_err_sticky: assert property (ris_r[R_UR] && !clr[R_UR] |=> ris_r[R_UR])
		else $error("error flag lost");

	c_done: cover property (done_ev && cnt == 16'h0004);
	c_underrun: cover property (ur_ev && !master);
	c_overflow: cover property (ov_ev);
	c_rx_pop: cover property (rx_pop);
endmodule

// *** testbench.sv ***
// self-checking bench: apb tasks, slave model in master mode, bench-driven slave link
// assumes zero-wait apb slave and registers as in the package
`timescale 1ns/1ps
module testbench
	import sftc_pkg::*;
;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, stx, srx;
	logic        sclk_i, ss_i_n, din_s, slv, sclk_o, sclk_oe_n, ss_o_n, dout_o, dout_oe_n;
	logic        irq, rx_data_available, tx_ready_for_more, miso;
	wire logic   din_i;
	int          fails, check_count, cyc;
	assign din_i = slv ? din_s : miso;
	sftc_top i_sftc_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sclk_i(sclk_i), .ss_i_n(ss_i_n), .din_i(din_i), .sclk_o(sclk_o),
		.sclk_oe_n(sclk_oe_n), .ss_o_n(ss_o_n), .dout_o(dout_o), .dout_oe_n(dout_oe_n),
		.irq(irq), .rx_data_available(rx_data_available),
		.tx_ready_for_more(tx_ready_for_more));
	sftc_slave_model i_sftc_slave_model (.sclk(sclk_o), .ss_n(ss_o_n), .mosi(dout_o),
		.miso(miso), .tx_word(stx), .bits(6'h08), .rx_word(srx));
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	task automatic stop_test();
		if (fails == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails = fails + 1;
			stop_test();
		end
	end
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		check_count++;
		if (s !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic waitfor(input bit dma);
		int n;
		for (n = 0; n < 3000 && (dma ? rx_data_available : irq) !== 1'b1; n++) @(posedge pclk);
		if (n == 3000) fails++;
	endtask
	initial begin
		{psel, penable, pwrite, sclk_i, din_s, slv, presetn} = 7'h00;
		{paddr, pwdata} = 40'h0;
		ss_i_n = 1'b1;
		stx = 32'h0000_00c5;
		fails = 0;
		check_count = 0;
		cyc = 0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, OFF_CTRL, 32'h0);
		chk("ctrl_reset", rd, CTRL_RST);
		apb(1'b0, OFF_STAT, 32'h0);
		chk("stat_reset", rd[4:0], 5'h14);
		apb(1'b0, 8'h1c, 32'h0);
		chk("unmapped", err, 1'b1);
		apb(1'b1, OFF_FSIZE, 32'h8);
		apb(1'b1, OFF_CLKGEN, 32'h3);
		apb(1'b1, OFF_TXD, 32'h11);
		apb(1'b0, OFF_STAT, 32'h0);
		chk("tx_next", rd[S_TXNXT], 1'b1);
		for (int i = 2; i < 6; i++) apb(1'b1, OFF_TXD, 32'h11 * i);
		apb(1'b0, OFF_STAT, 32'h0);
		chk("tx_full", rd[S_TXFUL], 1'b1);
		chk("rfm_full", tx_ready_for_more, 1'b0);
		apb(1'b1, OFF_CTRL, 32'h0004_000b);
		repeat (150) @(posedge pclk);
		chk("ss_mid", ss_o_n, 1'b0);
		apb(1'b0, OFF_RIS, 32'h0);
		chk("done_early", rd[R_TD], 1'b0);
		waitfor(1'b0);
		apb(1'b0, OFF_STAT, 32'h0);
		chk("sent", rd[S_SENT], 1'b1);
		chk("rx_full", rd[S_RXFUL], 1'b1);
		chk("tx_empty", rd[S_TXEMP], 1'b1);
		chk("oe_end", {ss_o_n, dout_oe_n}, 2'h3);
		chk("mosi", srx, 32'h1122_3344);
		chk("rx_avail", rx_data_available, 1'b1);
		chk("rfm_done", tx_ready_for_more, 1'b1);
		apb(1'b1, OFF_ICLR, 32'hf);
		stx = 32'h0000_003c;
		apb(1'b1, OFF_CTRL, 32'h0001_004b);
		apb(1'b1, OFF_TXD, 32'h66);
		waitfor(1'b0);
		apb(1'b0, OFF_RIS, 32'h0);
		chk("overflow", {rd[R_OV], rd[R_TD]}, 2'h3);
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, OFF_RXD, 32'h0);
			chk("rx_word", rd, 32'hc5);
		end
		apb(1'b0, OFF_STAT, 32'h0);
		chk("drained", {rd[S_RXEMP], rd[S_OV]}, 2'h3);
		apb(1'b1, OFF_ICLR, 32'h8);
		apb(1'b0, OFF_RIS, 32'h0);
		chk("ov_clear", rd[R_OV], 1'b0);
		apb(1'b1, OFF_ICLR, 32'hf);
		apb(1'b1, OFF_CTRL, 32'h0002_0023);
		apb(1'b1, OFF_TXD, 32'h77);
		waitfor(1'b0);
		apb(1'b0, OFF_RIS, 32'h0);
		chk("underrun", {rd[R_UR], rd[R_TD]}, 2'h2);
		chk("idle", ss_o_n, 1'b1);
		apb(1'b0, OFF_RXD, 32'h0);
		chk("rx_first", rd, 32'h3c);
		apb(1'b1, OFF_ICLR, 32'hf);
		apb(1'b1, OFF_TXD, 32'h99);
		apb(1'b1, OFF_TXD, 32'haa);
		apb(1'b1, OFF_CTRL, 32'h0002_000b);
		waitfor(1'b0);
		apb(1'b0, OFF_RIS, 32'h0);
		chk("restart", rd[R_TD], 1'b1);
		apb(1'b0, OFF_RXD, 32'h0);
		apb(1'b0, OFF_RXD, 32'h0);
		apb(1'b1, OFF_ICLR, 32'hf);
		apb(1'b1, OFF_CTRL, 32'h0001_001f);
		apb(1'b1, OFF_TXD, 32'h88);
		waitfor(1'b1);
		repeat (4) @(posedge pclk);
		chk("dma_irq", irq, 1'b0);
		apb(1'b0, OFF_MIS, 32'h0);
		chk("dma_mis", rd[3:0], 4'h0);
		apb(1'b0, OFF_RXD, 32'h0);
		apb(1'b1, OFF_ICLR, 32'hf);
		apb(1'b1, OFF_CTRL, 32'h0001_0021);
		apb(1'b1, OFF_FSIZE, 32'h4);
		apb(1'b1, OFF_TXD, 32'h5);
		slv = 1'b1;
		@(posedge pclk);
		#1 ss_i_n = 1'b0;
		// one word loaded: first frame runs, the request after it finds the fifo empty
		for (int i = 3; i >= 0; i--) begin
			din_s = i[0];
			#24 sclk_i = 1'b1;
			#24 sclk_i = 1'b0;
		end
		#24 ss_i_n = 1'b1;
		repeat (10) @(posedge pclk);
		chk("slv_irq", irq, 1'b1);
		chk("slv_avail", rx_data_available, 1'b1);
		apb(1'b0, OFF_RIS, 32'h0);
		chk("slv_underrun", rd[R_UR], 1'b1);
		apb(1'b0, OFF_RXD, 32'h0);
		chk("slv_rx", rd, 32'ha);
		stop_test();
	end
endmodule
